// ==== acr_pkg.sv ====
/*
 Constants and types shared by the converter configuration register bank:
 register addresses, reset values, field positions, opcodes and states.
 Assumes the includer refers to every item as acr_pkg::name.
*/
package acr_pkg;

	// Register addresses on the 4-bit register space
	localparam logic [3:0] ADDR_OFC_LOW = 4'h4;
	localparam logic [3:0] ADDR_OFC_MID = 4'h5;
	localparam logic [3:0] ADDR_OFC_HIGH = 4'h6;
	localparam logic [3:0] ADDR_FSC_LOW = 4'h7;
	localparam logic [3:0] ADDR_FSC_MID = 4'h8;
	localparam logic [3:0] ADDR_FSC_HIGH = 4'h9;
	localparam logic [3:0] ADDR_EXC_MAG = 4'ha;
	localparam logic [3:0] ADDR_EXC_ROUTE = 4'hb;
	localparam logic [3:0] ADDR_PIN_FUNC = 4'hc;
	localparam logic [3:0] ADDR_PIN_DIR = 4'hd;
	localparam logic [3:0] ADDR_PIN_DATA = 4'he;

	// Values after reset
	localparam logic [23:0] RST_OFFSET_COEF = 24'h000000;
	localparam logic [23:0] RST_FULLSCALE_COEF = 24'h000000;
	localparam logic [3:0] RST_EXC_MODE_MAG = 4'h0;
	localparam logic [7:0] RST_EXC_ROUTE = 8'hff;
	localparam logic [7:0] RST_PIN_REG = 8'h00;
	localparam logic [2:0] RST_GAIN = 3'h0;

	// Field positions inside the excitation magnitude and routing registers
	localparam int REV_LSB = 4;
	localparam int MODE_BIT = 3;
	localparam int SRC1_LSB = 4;

	// Command opcodes, upper nibble of the first byte
	localparam logic [3:0] OP_REG_WRITE = 4'h4;
	localparam logic [3:0] OP_REG_READ = 4'h2;

	// Cycle counts
	localparam logic [1:0] RELOAD_WAIT = 2'h2;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// Serial command sequencer states
	typedef enum logic [2:0]
	{
		ST_CMD = 3'b000,
		ST_COUNT_WR = 3'b001,
		ST_COUNT_RD = 3'b010,
		ST_WDATA = 3'b011,
		ST_RDATA = 3'b100
	} acr_spi_state_t;

endpackage

// ==== acr_trim_rom.sv ====
/*
 Factory trim store: one full-scale coefficient per gain setting,
 read data registered.
 Assumes the trim contents are set by parameter at build time.
*/
`timescale 1ns/10ps

module acr_trim_rom
#(
	parameter int GAIN_BITS = 3,
	parameter int COEF_WIDTH = 24,
	// Arbitrary neutral trim contents, one word per gain code
	parameter logic [(2**GAIN_BITS)*COEF_WIDTH-1:0] TRIM_TABLE = {(2**GAIN_BITS){24'h400000}}
)
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [GAIN_BITS-1:0] gain_in,
	output logic [COEF_WIDTH-1:0] trim_out
);

	logic [COEF_WIDTH-1:0] trim_reg;
	logic [COEF_WIDTH-1:0] trim_next;

	// Word select by gain code
	always_comb
	begin
		trim_next = TRIM_TABLE[gain_in*COEF_WIDTH +: COEF_WIDTH];
	end

	// Registered read, one cycle after the gain code
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			trim_reg <= '0;
		else
			trim_reg <= trim_next;
	end

	assign trim_out = trim_reg;

endmodule

// ==== acr_cal_regs.sv ====
/*
 Configuration register bank of a delta-sigma converter: calibration
 coefficients, excitation source control, revision field, output pin
 mode and shared general-purpose pins, reached by register read and
 write commands over the serial port.
 Assumes serial pins are synchronous to clk_in and sclk is far slower
 than clk_in; the gain code comes from the system control register.
 Only the register read and write commands are decoded here; other
 command bytes are skipped one byte at a time.
*/
`timescale 1ns/10ps

module acr_cal_regs
#(
	parameter int PIN_COUNT = 8,
	parameter logic [3:0] REVISION = 4'h0, // Arbitrary value
	parameter logic [8*24-1:0] TRIM_TABLE = {8{24'h400000}}
)
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic cs_n_in,
	input wire logic sclk_in,
	input wire logic din_in,
	input wire logic [2:0] gain_amplifier_in,
	input wire logic conv_ready_n_in,
	input wire logic [7:0] pin_in,
	output logic serial_out_ready_pin_out,
	output logic data_ready_n_out,
	output logic [23:0] offset_coefficient_out,
	output logic [23:0] fullscale_coefficient_out,
	output logic [2:0] excitation_magnitude_out,
	output logic output_pin_mode_bit_out,
	output logic [3:0] source1_route_out,
	output logic [3:0] source2_route_out,
	output logic [9:0] source1_sel_out,
	output logic [9:0] source2_sel_out,
	output logic [7:0] pin_analog_out,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe_out
);

	// Bits of the pin registers that exist in this variant
	// PIN_COUNT of 8 keeps all bits; 4 gives the smaller variant
	localparam logic [7:0] PIN_MASK = 8'(({8{1'b1}}) >> (8 - PIN_COUNT));

	// Whole block state in one record, registered as a unit
	typedef struct packed
	{
		acr_pkg::acr_spi_state_t st;
		logic sclk_q;
		logic [2:0] bits;
		logic [7:0] rx;
		logic [7:0] tx;
		logic [3:0] addr;
		logic [3:0] cnt;
		logic [23:0] offset_coefficient;
		logic [23:0] fullscale_coefficient;
		logic [3:0] mode_mag;
		logic [7:0] route;
		logic [7:0] cfg;
		logic [7:0] dir;
		logic [7:0] dat;
		logic [2:0] gain_last;
		logic [1:0] reload;
		logic dout;
		logic data_ready_n_n;
		logic [7:0] p_out;
		logic [7:0] p_oe;
		logic [7:0] p_ana;
		logic [9:0] s1_sel;
		logic [9:0] s2_sel;
	} acr_regs_t;

	// Registered state and its next value
	acr_regs_t state_reg;
	acr_regs_t state_next;
	logic [23:0] trim_data;
	logic sclk_fall;
	logic sclk_rise;
	logic [7:0] byte_in;

	// Trim word for the gain code now in force
	// Its read lags the gain code by one clock, hence the reload wait
	acr_trim_rom #(
		.GAIN_BITS(3),
		.COEF_WIDTH(24),
		.TRIM_TABLE(TRIM_TABLE)
	) u_trim (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.gain_in(gain_amplifier_in),
		.trim_out(trim_data)
	);

	// Edge detect on the sampled serial clock
	// One sampled copy suffices because sclk is far slower than clk_in
	// Reset value low matches the idle clock, so no false edge follows reset
	assign sclk_fall = state_reg.sclk_q & ~sclk_in;
	assign sclk_rise = ~state_reg.sclk_q & sclk_in;
	assign byte_in = {state_reg.rx[6:0], din_in};

	// Route nibble to one-hot: [7:0] analog inputs, [8] ext pin 1, [9] ext pin 2
	// Codes 11xx leave every select bit low, the source disconnected
	function automatic logic [9:0] route_dec(input logic [3:0] code);
		logic [9:0] sel;
		sel = 10'h000;
		if (!code[3])
			sel[code[2:0]] = 1'b1;
		else if (!code[2])
			sel[{3'h4, code[0]}] = 1'b1;
		return sel;
	endfunction

	// Read value of one register; unmapped addresses read zero
	// Missing variant pin bits are masked so they always read zero
	function automatic logic [7:0] rd_byte(input acr_regs_t s, input logic [3:0] a, input logic [7:0] pins);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			acr_pkg::ADDR_OFC_LOW: v = s.offset_coefficient[7:0];
			acr_pkg::ADDR_OFC_MID: v = s.offset_coefficient[15:8];
			acr_pkg::ADDR_OFC_HIGH: v = s.offset_coefficient[23:16];
			acr_pkg::ADDR_FSC_LOW: v = s.fullscale_coefficient[7:0];
			acr_pkg::ADDR_FSC_MID: v = s.fullscale_coefficient[15:8];
			acr_pkg::ADDR_FSC_HIGH: v = s.fullscale_coefficient[23:16];
			acr_pkg::ADDR_EXC_MAG: v = {REVISION, s.mode_mag};
			acr_pkg::ADDR_EXC_ROUTE: v = s.route;
			acr_pkg::ADDR_PIN_FUNC: v = s.cfg & PIN_MASK;
			acr_pkg::ADDR_PIN_DIR: v = s.dir & PIN_MASK;
			acr_pkg::ADDR_PIN_DATA: v = ((s.dat & ~s.dir) | (pins & s.dir)) & PIN_MASK;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// Next-state logic: serial commands, register writes, trim reload, pins
	always_comb
	begin
		state_next = state_reg;
		state_next.sclk_q = sclk_in;

		// Trim reload waits one cycle for the trim store's registered read
		if (gain_amplifier_in != state_reg.gain_last)
		begin
			state_next.gain_last = gain_amplifier_in;
			state_next.reload = acr_pkg::RELOAD_WAIT;
		end
		else if (state_reg.reload != 2'h0)
		begin
			state_next.reload = state_reg.reload - 2'h1;
		end

		// Load lands when the countdown reaches one; a same-cycle write beats it
		if (state_reg.reload == 2'h1 && gain_amplifier_in == state_reg.gain_last)
		begin
			state_next.fullscale_coefficient = trim_data;
		end

		// Deselect aborts any command in flight
		// A partial byte is dropped; the next select starts afresh
		if (cs_n_in)
		begin
			state_next.st = acr_pkg::ST_CMD;
			state_next.bits = 3'h0;
		end
		else if (sclk_fall)
		begin
			state_next.rx = byte_in;
			state_next.bits = state_reg.bits + 3'h1;
			// Eighth falling edge: act on the completed byte
			if (state_reg.bits == acr_pkg::LAST_BIT)
			begin
				case (state_reg.st)
					acr_pkg::ST_CMD:
					begin
						// Address kept for both commands; other opcodes fall through
						state_next.addr = byte_in[3:0];
						if (byte_in[7:4] == acr_pkg::OP_REG_WRITE)
							state_next.st = acr_pkg::ST_COUNT_WR;
						else if (byte_in[7:4] == acr_pkg::OP_REG_READ)
							state_next.st = acr_pkg::ST_COUNT_RD;
						else
							state_next.st = acr_pkg::ST_CMD; // Single-byte commands belong elsewhere
					end
					acr_pkg::ST_COUNT_WR:
					begin
						state_next.cnt = byte_in[3:0];
						state_next.st = acr_pkg::ST_WDATA;
					end
					acr_pkg::ST_COUNT_RD:
					begin
						state_next.cnt = byte_in[3:0];
						// First read byte captured now, pin levels included
						state_next.tx = rd_byte(state_reg, state_reg.addr, pin_in);
						state_next.st = acr_pkg::ST_RDATA;
					end
					acr_pkg::ST_WDATA:
					begin
						// Write lands on the byte boundary, then the address steps on
						case (state_reg.addr)
							acr_pkg::ADDR_OFC_LOW: state_next.offset_coefficient[7:0] = byte_in;
							acr_pkg::ADDR_OFC_MID: state_next.offset_coefficient[15:8] = byte_in;
							acr_pkg::ADDR_OFC_HIGH: state_next.offset_coefficient[23:16] = byte_in;
							acr_pkg::ADDR_FSC_LOW: state_next.fullscale_coefficient[7:0] = byte_in;
							acr_pkg::ADDR_FSC_MID: state_next.fullscale_coefficient[15:8] = byte_in;
							acr_pkg::ADDR_FSC_HIGH: state_next.fullscale_coefficient[23:16] = byte_in;
							acr_pkg::ADDR_EXC_MAG: state_next.mode_mag = byte_in[3:0];
							acr_pkg::ADDR_EXC_ROUTE: state_next.route = byte_in;
							acr_pkg::ADDR_PIN_FUNC: state_next.cfg = byte_in & PIN_MASK;
							acr_pkg::ADDR_PIN_DIR: state_next.dir = byte_in & PIN_MASK;
							acr_pkg::ADDR_PIN_DATA: state_next.dat = byte_in & PIN_MASK;
							default: state_next.rx = byte_in; // Unmapped or foreign address, dropped
						endcase
						state_next.addr = state_reg.addr + 4'h1;
						state_next.cnt = state_reg.cnt - 4'h1;
						// Count zero means this was the last data byte
						if (state_reg.cnt == 4'h0)
							state_next.st = acr_pkg::ST_CMD;
					end
					acr_pkg::ST_RDATA:
					begin
						// Host bytes during readout are ignored; address wraps at 15
						state_next.addr = state_reg.addr + 4'h1;
						state_next.cnt = state_reg.cnt - 4'h1;
						state_next.tx = rd_byte(state_reg, state_reg.addr + 4'h1, pin_in);
						if (state_reg.cnt == 4'h0)
							state_next.st = acr_pkg::ST_CMD;
					end
					default:
					begin
						state_next.st = acr_pkg::ST_CMD;
					end
				endcase
			end
		end
		else if (sclk_rise && state_reg.st == acr_pkg::ST_RDATA)
		begin
			// Data changes on the rising edge so the host samples on falling
			state_next.dout = state_reg.tx[7];
			state_next.tx = {state_reg.tx[6:0], 1'b0};
		end

		// During readout the pin keeps the last shifted data bit
		// Outside readout the shared out pin shows ready only in mode 1
		if (state_next.st != acr_pkg::ST_RDATA)
		begin
			if (state_next.mode_mag[acr_pkg::MODE_BIT])
				state_next.dout = conv_ready_n_in;
			else
				state_next.dout = 1'b1;
		end

		// Dedicated ready pin follows the converter in every mode
		state_next.data_ready_n_n = conv_ready_n_in;

		// Pin functions, direction and drive, registered for clean outputs
		// Output enable needs both the digital function and output direction
		state_next.p_ana = ~state_next.cfg & PIN_MASK;
		state_next.p_oe = state_next.cfg & ~state_next.dir & PIN_MASK;
		state_next.p_out = state_next.dat & state_next.p_oe;

		// Excitation routing decode
		// Taken from the next value so code and select change together
		state_next.s1_sel = route_dec(state_next.route[7:4]);
		state_next.s2_sel = route_dec(state_next.route[3:0]);
	end

	// State register with synchronous reset to power-up values
	// Full-scale word starts at zero and picks up its trim two clocks later with gain code 0, three with any other
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			state_reg.st <= acr_pkg::ST_CMD;
			state_reg.sclk_q <= 1'b0;
			state_reg.bits <= 3'h0;
			state_reg.rx <= 8'h00;
			state_reg.tx <= 8'h00;
			state_reg.addr <= 4'h0;
			state_reg.cnt <= 4'h0;
			state_reg.offset_coefficient <= acr_pkg::RST_OFFSET_COEF;
			state_reg.fullscale_coefficient <= acr_pkg::RST_FULLSCALE_COEF;
			state_reg.mode_mag <= acr_pkg::RST_EXC_MODE_MAG;
			state_reg.route <= acr_pkg::RST_EXC_ROUTE;
			state_reg.cfg <= acr_pkg::RST_PIN_REG;
			state_reg.dir <= acr_pkg::RST_PIN_REG;
			state_reg.dat <= acr_pkg::RST_PIN_REG;
			state_reg.gain_last <= acr_pkg::RST_GAIN;
			state_reg.reload <= acr_pkg::RELOAD_WAIT;
			state_reg.dout <= 1'b1;
			state_reg.data_ready_n_n <= 1'b1;
			state_reg.p_out <= 8'h00;
			state_reg.p_oe <= 8'h00;
			state_reg.p_ana <= PIN_MASK;
			state_reg.s1_sel <= 10'h000;
			state_reg.s2_sel <= 10'h000;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from the state register
	assign serial_out_ready_pin_out = state_reg.dout;
	assign data_ready_n_out = state_reg.data_ready_n_n;
	assign offset_coefficient_out = state_reg.offset_coefficient;
	assign fullscale_coefficient_out = state_reg.fullscale_coefficient;

	// Excitation and output pin mode fields
	assign excitation_magnitude_out = state_reg.mode_mag[2:0];
	assign output_pin_mode_bit_out = state_reg.mode_mag[acr_pkg::MODE_BIT];
	assign source1_route_out = state_reg.route[acr_pkg::SRC1_LSB +: 4];
	assign source2_route_out = state_reg.route[3:0];
	assign source1_sel_out = state_reg.s1_sel;
	assign source2_sel_out = state_reg.s2_sel;

	// Shared pin controls
	assign pin_analog_out = state_reg.p_ana;
	assign pin_out = state_reg.p_out;
	assign pin_oe_out = state_reg.p_oe;

endmodule

// ==== acr_spi_host.sv ====
/*
 Serial host model that issues register commands to the bank.
 Assumes clk_in is the bank's clock; sclk stays low between frames.
*/
`timescale 1ns/10ps
module acr_spi_host
(
	input wire logic clk_in,
	input wire logic dout_in,
	output logic cs_n_out,
	output logic sclk_out,
	output logic din_out
);
	// Idle: deselected, clock low
	initial
	begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		din_out = 1'b0;
	end
	// Gap before select so an earlier frame is surely closed
	task open_f();
		repeat (3) @(posedge clk_in);
		cs_n_out <= 1'b0;
		repeat (3) @(posedge clk_in);
	endtask
	// Released data line shows the inverse, never a stale bit
	task close_f();
		cs_n_out <= 1'b1;
		din_out <= ~din_out;
	endtask
	// MSB first; data set with the rise, read back late in the high phase
	task xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			sclk_out <= 1'b1;
			din_out <= tx[i];
			repeat (6) @(posedge clk_in);
			rx[i] = dout_in;
			sclk_out <= 1'b0;
			repeat (6) @(posedge clk_in);
		end
	endtask
endmodule

// ==== acr_cal_regs_assertions.sv ====
/*
 Concurrent checks on the register bank's pins.
 Assumes it is bound into acr_cal_regs and shares its parameters.
*/
`timescale 1ns/10ps
module acr_chk
#(
	parameter logic [8*24-1:0] TRIM_TABLE = {8{24'h400000}}
)
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic cs_n_in,
	input wire logic [2:0] gain_amplifier_in,
	input wire logic conv_ready_n_in,
	input wire logic serial_out_ready_pin_out,
	input wire logic data_ready_n_out,
	input wire logic [23:0] offset_coefficient_out,
	input wire logic [23:0] fullscale_coefficient_out,
	input wire logic output_pin_mode_bit_out,
	input wire logic [3:0] source1_route_out,
	input wire logic [3:0] source2_route_out,
	input wire logic [9:0] source1_sel_out,
	input wire logic [9:0] source2_sel_out,
	input wire logic [7:0] pin_analog_out,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);
	// Route code to one-hot select; 11xx leaves the source off
	function automatic logic [9:0] dec(input logic [3:0] r);
		if (!r[3])
			return 10'h001 << r[2:0];
		return r[2] ? 10'h000 : (r[0] ? 10'h200 : 10'h100);
	endfunction
	property p_reset;
		disable iff (1'b0) !rstn_in |=> offset_coefficient_out == 24'h0 && source1_route_out == 4'hf && pin_oe_out == 8'h00;
	endproperty
	a_reset: assert property (p_reset) else $error("reset values wrong");
	property p_ready;
		$past(rstn_in) |-> data_ready_n_out == $past(conv_ready_n_in);
	endproperty
	a_ready: assert property (p_ready) else $error("ready pin not following converter");
	property p_drive;
		(pin_out & ~pin_oe_out) == 8'h00;
	endproperty
	a_drive: assert property (p_drive) else $error("pin driven high while not enabled");
	property p_analog;
		(pin_analog_out & pin_oe_out) == 8'h00;
	endproperty
	a_analog: assert property (p_analog) else $error("analog pin driven");
	property p_src1;
		$stable(source1_route_out) |-> source1_sel_out == dec(source1_route_out);
	endproperty
	a_src1: assert property (p_src1) else $error("first source select wrong");
	property p_src2;
		$stable(source2_route_out) |-> source2_sel_out == dec(source2_route_out);
	endproperty
	a_src2: assert property (p_src2) else $error("second source select wrong");
	property p_idle;
		cs_n_in && $past(cs_n_in) && !output_pin_mode_bit_out && !$past(output_pin_mode_bit_out) |-> serial_out_ready_pin_out;
	endproperty
	a_idle: assert property (p_idle) else $error("serial out not high in data-only mode");
	property p_ready_mode;
		$past(cs_n_in) && output_pin_mode_bit_out |-> serial_out_ready_pin_out == data_ready_n_out;
	endproperty
	a_ready_mode: assert property (p_ready_mode) else $error("serial out not showing ready in mode 1");
	property p_trim;
		($rose(rstn_in) || $changed(gain_amplifier_in)) && cs_n_in ##1 (cs_n_in && $stable(gain_amplifier_in)) [*3]
			|=> fullscale_coefficient_out == TRIM_TABLE[24*gain_amplifier_in +: 24];
	endproperty
	a_trim: assert property (p_trim) else $error("trim value not loaded");
endmodule

bind acr_cal_regs acr_chk #(.TRIM_TABLE(TRIM_TABLE)) acr_chk_i (.clk_in, .rstn_in, .cs_n_in, .gain_amplifier_in,
	.conv_ready_n_in, .serial_out_ready_pin_out, .data_ready_n_out, .offset_coefficient_out, .fullscale_coefficient_out,
	.output_pin_mode_bit_out, .source1_route_out, .source2_route_out, .source1_sel_out, .source2_sel_out,
	.pin_analog_out, .pin_out, .pin_oe_out);

// ==== adc_cal_excitation_gpio_regs_tb.sv ====
/*
 Self-checking bench for the register bank: table, bursts, wrap, reloads.
 Assumes the host model and checker are compiled before it.
*/
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin fail_count++; $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module adc_cal_excitation_gpio_regs_tb;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic conv_ready_n_in = 1'b1;
	logic [2:0] gain_amplifier_in = 3'h0;
	logic [7:0] pin_in = 8'h3c;
	logic cs_n_in, sclk_in, din_in, serial_out_ready_pin_out, data_ready_n_out, output_pin_mode_bit_out;
	logic [23:0] offset_coefficient_out, fullscale_coefficient_out;
	logic [2:0] excitation_magnitude_out;
	logic [3:0] source1_route_out, source2_route_out;
	logic [9:0] source1_sel_out, source2_sel_out;
	logic [7:0] pin_analog_out, pin_out, pin_oe_out, rx;
	int fail_count = 0;
	int comparisons = 0;
	int cyc = 0;
	// Address, value written, value read back (upper pins absent)
	logic [19:0] rows [13] = '{20'h41111, 20'h52222, 20'h63333, 20'h7a1a1, 20'h8b2b2, 20'h9c3c3, 20'hafd9d,
		20'hb5a5a, 20'hcff0f, 20'hdfa0a, 20'hef50d, 20'h37700, 20'hf6600};
	initial
	begin
		forever #25 clk_in = ~clk_in;
	end
	// Ready pulses and hang guard
	always @(posedge clk_in)
	begin
		cyc <= cyc + 1;
		conv_ready_n_in <= cyc[4:0] != 5'h00;
		if (cyc > 60000)
		begin
			fail_count++;
			close_out();
		end
	end
	acr_spi_host acr_spi_host_i (.clk_in, .dout_in(serial_out_ready_pin_out), .cs_n_out(cs_n_in),
		.sclk_out(sclk_in), .din_out(din_in));
	// Smaller variant, arbitrary revision, distinct trims so a reload shows
	acr_cal_regs #(.PIN_COUNT(4), .REVISION(4'h9), .TRIM_TABLE({24'h400007, 24'h400006, 24'h400005, 24'h400004,
		24'h400003, 24'h400002, 24'h400001, 24'h400000})) acr_cal_regs_i (.clk_in, .rstn_in, .cs_n_in, .sclk_in,
		.din_in, .gain_amplifier_in, .conv_ready_n_in, .pin_in, .serial_out_ready_pin_out, .data_ready_n_out,
		.offset_coefficient_out, .fullscale_coefficient_out, .excitation_magnitude_out, .output_pin_mode_bit_out,
		.source1_route_out, .source2_route_out, .source1_sel_out, .source2_sel_out, .pin_analog_out, .pin_out,
		.pin_oe_out);
	task close_out();
		if (fail_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Single-register write
	task wr(input logic [3:0] a, input logic [7:0] d);
		acr_spi_host_i.open_f();
		acr_spi_host_i.xfer({acr_pkg::OP_REG_WRITE, a}, rx);
		acr_spi_host_i.xfer(8'h00, rx);
		acr_spi_host_i.xfer(d, rx);
		acr_spi_host_i.close_f();
	endtask
	// Read n+1 registers, no-ops clocked out meanwhile; first byte in ex's top
	task rd(input logic [3:0] a, input logic [3:0] n, input logic [63:0] ex);
		acr_spi_host_i.open_f();
		acr_spi_host_i.xfer({acr_pkg::OP_REG_READ, a}, rx);
		acr_spi_host_i.xfer({4'h0, n}, rx);
		for (int k = 0; k <= n; k++)
		begin
			acr_spi_host_i.xfer(8'hff, rx);
			`CHK("read", ex[63-8*k -: 8], rx)
		end
		acr_spi_host_i.close_f();
	endtask
	initial
	begin
		repeat (10) @(posedge clk_in);
		rstn_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		`CHK("fullscale", 24'h400000, fullscale_coefficient_out)
		rd(4'hb, 4'h0, 64'hff << 56);
		rd(4'ha, 4'h0, 64'h90 << 56);
		for (int k = 0; k < 13; k++)
		begin
			wr(rows[k][19:16], rows[k][15:8]);
			rd(rows[k][19:16], 4'h0, {rows[k][7:0], 56'h0});
		end
		`CHK("offset", 24'h332211, offset_coefficient_out)
		`CHK("fullscale", 24'hc3b2a1, fullscale_coefficient_out)
		`CHK("mode", 1'b1, output_pin_mode_bit_out)
		`CHK("src1", 10'h020, source1_sel_out)
		`CHK("src2", 10'h100, source2_sel_out)
		`CHK("oe", 8'h05, pin_oe_out)
		`CHK("drive", 8'h05, pin_out)
		`CHK("analog", 8'h00, pin_analog_out)
		// Codes only stored here; the host has the reference on first
		for (int c = 0; c < 8; c++)
		begin
			wr(4'ha, 8'(c));
			`CHK("magnitude", 3'(c), excitation_magnitude_out)
		end
		// Stray single-byte command, then a routing write in the same frame
		acr_spi_host_i.open_f();
		acr_spi_host_i.xfer(8'hff, rx);
		acr_spi_host_i.xfer({acr_pkg::OP_REG_WRITE, acr_pkg::ADDR_EXC_ROUTE}, rx);
		acr_spi_host_i.xfer(8'h00, rx);
		acr_spi_host_i.xfer(8'h9c, rx);
		acr_spi_host_i.close_f();
		`CHK("src1", 10'h200, source1_sel_out)
		`CHK("src2", 10'h000, source2_sel_out)
		// Three-byte burst into the offset coefficient
		acr_spi_host_i.open_f();
		acr_spi_host_i.xfer({acr_pkg::OP_REG_WRITE, acr_pkg::ADDR_OFC_LOW}, rx);
		acr_spi_host_i.xfer(8'h02, rx);
		for (int k = 1; k < 4; k++)
			acr_spi_host_i.xfer(8'(k), rx);
		acr_spi_host_i.close_f();
		`CHK("burst", 24'h030201, offset_coefficient_out)
		rd(4'he, 4'h7, 64'h0d00000000000102);
		gain_amplifier_in <= 3'h3;
		repeat (6) @(posedge clk_in);
		`CHK("reload", 24'h400003, fullscale_coefficient_out)
		rstn_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rstn_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		`CHK("offset", 24'h0, offset_coefficient_out)
		`CHK("fullscale", 24'h400003, fullscale_coefficient_out)
		rd(4'hc, 4'h0, 64'h0);
		close_out();
	end
endmodule
